// file: hdl/gptimer.sv
// general-purpose timer block with alternate clock, avalon-mm register slave
//
// Behaviour
// - sync reloads every selected timer, RTC included
// - properties bit reads one when alternate clock present
// - value, capture, predivide reads are coherent snapshots
// - adc and dma triggers fire reliably on alt clock
// - edge count up returns to zero at match
// - match and load always writable
// - sync bits self-clear with alternate clock too
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module gptimer
    import gptimer_pkg::*;
#(
    parameter logic [DW-1:0] PREDIV_TOP = PREDIV_TOP_DEF
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // avalon-mm slave
    input wire logic [AW-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [DW-1:0] WRITEDATA,
    output logic [DW-1:0] READDATA,
    output logic WAITREQUEST,
    // pins
    input wire logic ALT_CLK,
    input wire logic [NT-1:0] EDGE_IN,
    // trigger consumers and interrupt
    output logic [NT-1:0] ADC_TRIG,
    output logic [NT-1:0] DMA_TRIG,
    output logic IRQ
);
    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    // true when addr selects word off of timer n
    function automatic logic tmr_hit(input logic [AW-1:0] addr, input int n,
                                     input logic [AW-1:0] off);
        logic [AW-1:0] a;
        a = OFS_TMR_BASE + AW'(n) * OFS_TMR_STRIDE + off;
        return addr == a;
    endfunction
    // byte-lane merge of a write into a held word
    function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old, input logic [DW-1:0] wd,
                                               input logic [3:0] be);
        logic [DW-1:0] r;
        for (int b = 0; b < 4; b++) begin
            r[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake
    logic ack_q;        // second cycle of an access
    logic wr_go;        // write takes effect this edge
    logic rd_go;        // read data captured this edge
    logic [DW-1:0] rdata_q; // registered read data
    // one wait state on every access; read data is built in the wait cycle
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (READ | WRITE) & ~ack_q;
        end
    end
    assign WAITREQUEST = (READ | WRITE) & ~ack_q;
    assign wr_go = WRITE & ack_q;
    assign rd_go = READ & ~ack_q;
    assign READDATA = rdata_q;
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic alt_s1_q, alt_s2_q, alt_s3_q;   // alternate clock sync chain
    logic [NT-1:0] edg_s1_q, edg_s2_q, edg_s3_q; // edge input sync chains
    logic alt_rise;                       // one cycle per rising alternate clock edge
    logic [NT-1:0] edg_rise;              // one cycle per rising input edge
    // first stages only feed second stages, edges are taken from stage two on
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            alt_s1_q <= 1'b0;
            alt_s2_q <= 1'b0;
            alt_s3_q <= 1'b0;
            edg_s1_q <= '0;
            edg_s2_q <= '0;
            edg_s3_q <= '0;
        end else begin
            alt_s1_q <= ALT_CLK;
            alt_s2_q <= alt_s1_q;
            alt_s3_q <= alt_s2_q;
            edg_s1_q <= EDGE_IN;
            edg_s2_q <= edg_s1_q;
            edg_s3_q <= edg_s2_q;
        end
    end
    assign alt_rise = alt_s2_q & ~alt_s3_q;
    assign edg_rise = edg_s2_q & ~edg_s3_q;
    ////////////////////////////////////////////////////////////////////////////////
    // global control registers
    logic clksel_q;         // alternate clock selected
    logic sel_alt;          // effective select, forced off when absent
    logic tick;             // counting enable for the timer domain
    logic [NT-1:0] sync_q;  // pending synchronise requests
    logic [NT-1:0] sync_take; // request applied this edge
    logic [2*NT-1:0] stat_q;  // sticky timeout and match events
    logic [2*NT-1:0] mask_q;  // interrupt enables
    logic [NT-1:0] ev_to;     // timeout events
    logic [NT-1:0] ev_mt;     // match events
    // clock select register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            clksel_q <= 1'b0;
        end else if (wr_go && ADDRESS == OFS_CLKSEL && BYTEENABLE[0]) begin
            clksel_q <= WRITEDATA[CLKSEL_ALT_BIT];
        end
    end
    // the timer domain advances once per rising alternate edge, or every cycle;
    // sampling the slow clock keeps all state in one domain, so reads stay coherent
    assign sel_alt = clksel_q & ALT_PRESENT;
    assign tick = sel_alt ? alt_rise : 1'b1;
    assign sync_take = sync_q & {NT{tick}};
    // sync bits self-clear once applied; a new write wins over the clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sync_q <= '0;
        end else begin
            sync_q <= (sync_q & ~sync_take)
                      | ((wr_go && ADDRESS == OFS_SYNC) ? WRITEDATA[NT-1:0] : '0);
        end
    end
    // interrupt mask
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            mask_q <= '0;
        end else if (wr_go && ADDRESS == OFS_MASK) begin
            mask_q <= WRITEDATA[2*NT-1:0];
        end
    end
    // sticky status, hardware set beats write-one clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~((wr_go && ADDRESS == OFS_STAT) ? WRITEDATA[2*NT-1:0] : '0))
                      | {ev_mt, ev_to};
        end
    end
    assign IRQ = |(stat_q & mask_q);
    ////////////////////////////////////////////////////////////////////////////////
    // timers
    logic [3:0] mode_q [NT];        // mode, up, enable as written
    logic [DW-1:0] load_q [NT];     // interval load
    logic [DW-1:0] match_q [NT];    // match value
    logic [DW-1:0] value_q [NT];    // live count
    logic [DW-1:0] capt_q [NT];     // count latched at each event
    logic [DW-1:0] prediv_q [NT];   // rtc predivider
    logic [NT-1:0] run_q;           // timer counting
    logic [NT-1:0] to_q;            // timeout pulse
    logic [NT-1:0] mt_q;            // match pulse
    logic [NT-1:0] trig_q;          // trigger pulse
    for (genvar n = 0; n < NT; n++) begin : g_tmr
        logic [1:0] md;         // mode field
        logic up;               // count direction
        logic wr_mode, wr_load, wr_match;
        assign md = mode_q[n][MODE_LSB +: 2];
        assign up = mode_q[n][MODE_UP_BIT];
        assign wr_mode = wr_go && tmr_hit(ADDRESS, n, OFS_T_MODE);
        assign wr_load = wr_go && tmr_hit(ADDRESS, n, OFS_T_LOAD);
        assign wr_match = wr_go && tmr_hit(ADDRESS, n, OFS_T_MATCH);
        // software registers; no clock or mode gates these writes
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                mode_q[n] <= RST_MODE;
                load_q[n] <= RST_LOAD;
                match_q[n] <= RST_ZERO;
            end else begin
                if (wr_mode && BYTEENABLE[0]) begin
                    mode_q[n] <= WRITEDATA[3:0];
                end
                if (wr_load) begin
                    load_q[n] <= be_merge(load_q[n], WRITEDATA, BYTEENABLE);
                end
                if (wr_match) begin
                    match_q[n] <= be_merge(match_q[n], WRITEDATA, BYTEENABLE);
                end
            end
        end
        // counter, predivider, capture and event pulses
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                value_q[n] <= RST_ZERO;
                capt_q[n] <= RST_ZERO;
                prediv_q[n] <= RST_ZERO;
                run_q[n] <= 1'b0;
                to_q[n] <= 1'b0;
                mt_q[n] <= 1'b0;
                trig_q[n] <= 1'b0;
            end else begin
                to_q[n] <= 1'b0;
                mt_q[n] <= 1'b0;
                trig_q[n] <= 1'b0;
                if (wr_mode && BYTEENABLE[0]) begin
                    // start or stop; a fresh start begins from the natural origin
                    run_q[n] <= WRITEDATA[MODE_EN_BIT];
                    value_q[n] <= WRITEDATA[MODE_UP_BIT] ? RST_ZERO : load_q[n];
                    prediv_q[n] <= RST_ZERO;
                end else if (sync_take[n]) begin
                    // synchronise: every mode, rtc too, restarts on the same tick
                    value_q[n] <= (up || md == MODE_RTC) ? RST_ZERO : load_q[n];
                    prediv_q[n] <= RST_ZERO;
                end else if (run_q[n]) begin
                    case (md)
                        MODE_ONESHOT, MODE_PERIODIC: begin
                            if (tick) begin
                                if (up ? (value_q[n] == load_q[n]) : (value_q[n] == RST_ZERO)) begin
                                    // timeout: trigger drawn in the system domain
                                    to_q[n] <= 1'b1;
                                    trig_q[n] <= 1'b1;
                                    capt_q[n] <= value_q[n];
                                    value_q[n] <= up ? RST_ZERO : load_q[n];
                                    if (md == MODE_ONESHOT) begin
                                        run_q[n] <= 1'b0;
                                    end
                                end else begin
                                    value_q[n] <= up ? value_q[n] + 1'b1 : value_q[n] - 1'b1;
                                end
                            end
                        end
                        MODE_EDGE: begin
                            if (edg_rise[n]) begin
                                if (up) begin
                                    if (value_q[n] + 1'b1 == match_q[n]) begin
                                        // wrap on the matching edge itself
                                        value_q[n] <= RST_ZERO;
                                        mt_q[n] <= 1'b1;
                                        capt_q[n] <= match_q[n];
                                    end else begin
                                        value_q[n] <= value_q[n] + 1'b1;
                                    end
                                end else if (value_q[n] - 1'b1 == match_q[n]) begin
                                    // capture match down: reload and trigger
                                    value_q[n] <= load_q[n];
                                    mt_q[n] <= 1'b1;
                                    trig_q[n] <= 1'b1;
                                    capt_q[n] <= match_q[n];
                                end else begin
                                    value_q[n] <= value_q[n] - 1'b1;
                                end
                            end
                        end
                        MODE_RTC: begin
                            if (tick) begin
                                if (prediv_q[n] == PREDIV_TOP) begin
                                    prediv_q[n] <= RST_ZERO;
                                    value_q[n] <= value_q[n] + 1'b1;
                                    if (value_q[n] + 1'b1 == match_q[n]) begin
                                        mt_q[n] <= 1'b1;
                                        capt_q[n] <= match_q[n];
                                    end
                                end else begin
                                    prediv_q[n] <= prediv_q[n] + 1'b1;
                                end
                            end
                        end
                        default: begin
                            run_q[n] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end
    assign ev_to = to_q;
    assign ev_mt = mt_q;
    assign ADC_TRIG = trig_q;
    assign DMA_TRIG = trig_q;
    ////////////////////////////////////////////////////////////////////////////////
    // read mux
    // snapshot taken in one system cycle, so a wide count never tears
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rdata_q <= RST_ZERO;
        end else if (rd_go) begin
            rdata_q <= RST_ZERO;
            case (ADDRESS)
                OFS_CLKSEL: rdata_q[CLKSEL_ALT_BIT] <= clksel_q;
                OFS_SYNC: rdata_q[NT-1:0] <= sync_q;
                OFS_PROPS: rdata_q[PROPS_ALT_BIT] <= ALT_PRESENT;
                OFS_STAT: rdata_q[2*NT-1:0] <= stat_q;
                OFS_MASK: rdata_q[2*NT-1:0] <= mask_q;
                default: begin
                    for (int n = 0; n < NT; n++) begin
                        if (tmr_hit(ADDRESS, n, OFS_T_MODE)) begin
                            rdata_q[3:0] <= {run_q[n], mode_q[n][2:0]};
                        end
                        if (tmr_hit(ADDRESS, n, OFS_T_LOAD)) begin
                            rdata_q <= load_q[n];
                        end
                        if (tmr_hit(ADDRESS, n, OFS_T_MATCH)) begin
                            rdata_q <= match_q[n];
                        end
                        if (tmr_hit(ADDRESS, n, OFS_T_VALUE)) begin
                            rdata_q <= value_q[n];
                        end
                        if (tmr_hit(ADDRESS, n, OFS_T_CAPT)) begin
                            rdata_q <= capt_q[n];
                        end
                        if (tmr_hit(ADDRESS, n, OFS_T_PREDIV)) begin
                            rdata_q <= prediv_q[n];
                        end
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // assertions on timer 0 and the properties bit
    property p_sync_rtc;
        @(posedge CLK) disable iff (!RSTN)
        sync_q[0] && tick && !(wr_go && tmr_hit(ADDRESS, 0, OFS_T_MODE))
            && mode_q[0][1:0] == MODE_RTC |=> value_q[0] == RST_ZERO && prediv_q[0] == RST_ZERO;
    endproperty
    a_sync_rtc: assert property (p_sync_rtc) else $error("rtc timer not synchronised");
    property p_props;
        @(posedge CLK) disable iff (!RSTN)
        READ && ack_q && ADDRESS == OFS_PROPS |-> READDATA[PROPS_ALT_BIT] == ALT_PRESENT;
    endproperty
    a_props: assert property (p_props) else $error("capability bit wrong");
    property p_value_read;
        @(posedge CLK) disable iff (!RSTN)
        READ && ack_q && tmr_hit(ADDRESS, 0, OFS_T_VALUE) |-> READDATA == $past(value_q[0]);
    endproperty
    a_value_read: assert property (p_value_read) else $error("value read incoherent");
    property p_trig;
        @(posedge CLK) disable iff (!RSTN)
        run_q[0] && tick && !sync_q[0] && !wr_go && mode_q[0][2:0] == {1'b0, MODE_ONESHOT}
            && value_q[0] == RST_ZERO |=> ADC_TRIG[0] && DMA_TRIG[0] && !run_q[0];
    endproperty
    a_trig: assert property (p_trig) else $error("timeout trigger missing");
    property p_edge_up;
        @(posedge CLK) disable iff (!RSTN)
        run_q[0] && edg_rise[0] && !sync_q[0] && !wr_go && mode_q[0][1:0] == MODE_EDGE
            && mode_q[0][MODE_UP_BIT] && value_q[0] + 1'b1 == match_q[0]
            |=> value_q[0] == RST_ZERO && mt_q[0] ##1 stat_q[STAT_MATCH_LSB];
    endproperty
    a_edge_up: assert property (p_edge_up) else $error("edge count up missed wrap");
    property p_load_write;
        @(posedge CLK) disable iff (!RSTN)
        wr_go && tmr_hit(ADDRESS, 0, OFS_T_LOAD) && BYTEENABLE == 4'hF
            |=> load_q[0] == $past(WRITEDATA);
    endproperty
    a_load_write: assert property (p_load_write) else $error("load write dropped");
    property p_sync_clear;
        @(posedge CLK) disable iff (!RSTN)
        sync_q[0] && tick && !(wr_go && ADDRESS == OFS_SYNC) |=> !sync_q[0];
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("sync bit stuck");
    property p_sync_hold;
        @(posedge CLK) disable iff (!RSTN)
        sync_q[0] && !tick |=> sync_q[0];
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync cleared before reload");
endmodule

// file: hdl/gptimer_pkg.sv
// shared constants for the general-purpose timer block
package gptimer_pkg;
    // block shape
    localparam int NT = 2;                          // number of timers
    localparam int DW = 32;                         // data and counter width
    localparam int AW = 8;                          // byte address width
    // global register byte offsets
    localparam logic [AW-1:0] OFS_CLKSEL = 8'h00;   // timer_clock_select_register
    localparam logic [AW-1:0] OFS_SYNC = 8'h04;     // timer_sync_register
    localparam logic [AW-1:0] OFS_PROPS = 8'h08;    // timer_properties_register
    localparam logic [AW-1:0] OFS_STAT = 8'h0C;     // sticky event status, write one to clear
    localparam logic [AW-1:0] OFS_MASK = 8'h10;     // interrupt mask
    // per-timer window
    localparam logic [AW-1:0] OFS_TMR_BASE = 8'h40;
    localparam logic [AW-1:0] OFS_TMR_STRIDE = 8'h20;
    localparam logic [AW-1:0] OFS_T_MODE = 8'h00;   // mode, direction, enable
    localparam logic [AW-1:0] OFS_T_LOAD = 8'h04;   // timer_interval_load_register
    localparam logic [AW-1:0] OFS_T_MATCH = 8'h08;  // timer_match_register
    localparam logic [AW-1:0] OFS_T_VALUE = 8'h0C;  // timer_value_register
    localparam logic [AW-1:0] OFS_T_CAPT = 8'h10;   // timer_capture_register
    localparam logic [AW-1:0] OFS_T_PREDIV = 8'h14; // rtc_predivide_register
    // field positions
    localparam int CLKSEL_ALT_BIT = 0;              // 1 selects the alternate clock
    localparam int PROPS_ALT_BIT = 0;               // alternate_clock_capable
    localparam int MODE_LSB = 0;                    // two-bit mode field
    localparam int MODE_UP_BIT = 2;                 // 1 counts up
    localparam int MODE_EN_BIT = 3;                 // 1 starts the timer
    localparam int STAT_MATCH_LSB = NT;             // timeout bits low, match bits above
    // mode encodings
    localparam logic [1:0] MODE_ONESHOT = 2'h0;
    localparam logic [1:0] MODE_PERIODIC = 2'h1;
    localparam logic [1:0] MODE_EDGE = 2'h2;
    localparam logic [1:0] MODE_RTC = 2'h3;
    // reset values
    localparam logic [DW-1:0] RST_ZERO = 32'h0000_0000;
    localparam logic [DW-1:0] RST_LOAD = 32'hFFFF_FFFF;
    localparam logic [3:0] RST_MODE = 4'h0;
    // alternate clock present on this build
    localparam logic ALT_PRESENT = 1'b1;
    // rtc predivide terminal count, default for the top parameter
    localparam logic [DW-1:0] PREDIV_TOP_DEF = 32'h0000_7FFF;
    // system clock rate, the alternate clock must be slower than half of it
    localparam int SYSCLK_HZ = 20_000_000;
endpackage

// file: verification/general_purpose_timer_alternate_clock_capable_tb_top.sv
// self-checking bench for the timer block, alternate clock and trigger paths
`timescale 1ns/1ps
module general_purpose_timer_alternate_clock_capable_tb_top
    import gptimer_pkg::*;
;
    logic clk, rstn, rd, wr, alt_clk, irq, wreq;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata, v;
    logic [NT-1:0] edges, adc, dma;
    int error_cnt, compares;
    ////////////////////////////////////////////////////////////////////////////////
    gptimer #(.PREDIV_TOP(32'h0000_0003)) i_dut (.CLK(clk), .RSTN(rstn), .ADDRESS(addr),
        .READ(rd), .WRITE(wr), .BYTEENABLE(4'hF), .WRITEDATA(wdata), .READDATA(rdata),
        .WAITREQUEST(wreq), .ALT_CLK(alt_clk), .EDGE_IN(edges), .ADC_TRIG(adc),
        .DMA_TRIG(dma), .IRQ(irq));
    trig_edge_model i_far (.clk(clk), .adc_trig(adc), .dma_trig(dma), .edge_out(edges));
    // system clock, 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // alternate clock, eight system cycles a period, well under a quarter of the rate
    always @(posedge clk) begin
        repeat (3) @(posedge clk);
        alt_clk <= ~alt_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access; request held until waitrequest is seen low at a rising edge,
    // read data taken at that same edge; a hung slave is left to the watchdog
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    function automatic logic [AW-1:0] ta(input int t, input logic [AW-1:0] o);
        return OFS_TMR_BASE + (t == 1 ? OFS_TMR_STRIDE : 8'h00) + o;
    endfunction
    function automatic logic [DW-1:0] md(input logic [1:0] m, input logic up);
        return {28'h000_0000, 1'b1, up, m};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // reset values, properties bit, unmapped place
    task automatic t_props;
        bus(0, OFS_PROPS, 0);
        check(v, 32'h0000_0001);
        bus(0, ta(0, OFS_T_LOAD), 0);
        check(v, RST_LOAD);
        bus(1, 8'hF0, 32'h1234_5678);
        bus(0, 8'hF0, 0);
        check(v, RST_ZERO);
    endtask
    // load and match stay writable on the alternate clock in 32-bit timing modes
    task automatic t_writable;
        bus(1, OFS_CLKSEL, 1);
        for (int m = 0; m < 2; m++) begin
            bus(1, ta(1, OFS_T_MODE), md(m[1:0], 1'b0));
            bus(1, ta(1, OFS_T_LOAD), 32'hA5A5_0000 + m);
            bus(1, ta(1, OFS_T_MATCH), 32'h0000_5A5A + m);
            bus(0, ta(1, OFS_T_LOAD), 0);
            check(v, 32'hA5A5_0000 + m);
            bus(0, ta(1, OFS_T_MATCH), 0);
            check(v, 32'h0000_5A5A + m);
        end
    endtask
    // edge count up: exactly three edges per match, every time
    task automatic t_edge_up;
        bus(1, ta(0, OFS_T_MATCH), 3);
        bus(1, ta(0, OFS_T_MODE), md(MODE_EDGE, 1'b1));
        i_far.send_edges(0, 3);
        bus(0, OFS_STAT, 0);
        check(v, 32'h0000_0004);
        bus(1, OFS_STAT, 32'h0000_0004);
        i_far.send_edges(0, 2);
        bus(0, ta(0, OFS_T_VALUE), 0);
        check(v, 32'h0000_0002);
        i_far.send_edges(0, 1);
        bus(0, ta(0, OFS_T_VALUE), 0);
        check(v, RST_ZERO);
        bus(0, OFS_STAT, 0);
        check(v, 32'h0000_0004);
        bus(1, OFS_STAT, 32'h0000_000F);
    endtask
    // triggers on the alternate clock: edge-count down match, one-shot timeout
    task automatic t_trig;
        bus(1, ta(1, OFS_T_LOAD), 10);
        bus(1, ta(1, OFS_T_MATCH), 8);
        bus(1, ta(1, OFS_T_MODE), md(MODE_EDGE, 1'b0));
        i_far.send_edges(1, 2);
        check(i_far.trig_cnt[1], 1);
        bus(1, OFS_MASK, 32'h0000_0001);
        bus(1, ta(0, OFS_T_LOAD), 5);
        bus(1, ta(0, OFS_T_MODE), md(MODE_ONESHOT, 1'b0));
        repeat (150) @(posedge clk);
        check(i_far.trig_cnt[0], 1);
        check(irq, 1);
        bus(0, ta(0, OFS_T_VALUE), 0);
        check(v, 5);
        bus(0, ta(1, OFS_T_CAPT), 0);
        check(v, 8);
        bus(1, OFS_STAT, 32'h0000_0001);
        // the clear lands on the edge the bus task returns at, so look one edge later
        @(posedge clk);
        check(irq, 0);
        check(i_far.pair_err, 0);
    endtask
    // sync reloads an rtc timer and a periodic one, bits clear by themselves
    task automatic t_sync;
        bus(1, ta(1, OFS_T_LOAD), 100);
        bus(1, ta(0, OFS_T_MATCH), 32'h00FF_FFFF);
        bus(1, ta(0, OFS_T_MODE), md(MODE_RTC, 1'b1));
        bus(1, ta(1, OFS_T_MODE), md(MODE_PERIODIC, 1'b0));
        repeat (300) @(posedge clk);
        bus(1, OFS_SYNC, 32'h0000_0003);
        repeat (30) @(posedge clk);
        bus(0, OFS_SYNC, 0);
        check(v, RST_ZERO);
        bus(0, ta(0, OFS_T_VALUE), 0);
        check(v <= 1, 1);
        bus(0, ta(1, OFS_T_VALUE), 0);
        check(v >= 95 && v <= 100, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {rstn, rd, wr, alt_clk, addr, wdata, error_cnt, compares} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_props;
        t_writable;
        t_edge_up;
        t_trig;
        t_sync;
        report_and_stop;
    end
    // watchdog, far beyond the roughly seven hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end
endmodule

// file: verification/trig_edge_model.sv
// far-side model: edge source for the count inputs, consumer of adc and dma triggers
`timescale 1ns/1ps
module trig_edge_model
    import gptimer_pkg::*;
(
    // clock
    input wire logic clk,
    // triggers from the timer
    input wire logic [NT-1:0] adc_trig,
    input wire logic [NT-1:0] dma_trig,
    // edge pins toward the timer
    output logic [NT-1:0] edge_out
);
    int trig_cnt [NT]; // pulses seen per timer
    int pair_err; // cycles where the two consumers disagreed
    initial begin
        edge_out = '0;
        pair_err = 0;
        foreach (trig_cnt[i]) trig_cnt[i] = 0;
    end
    // count one-cycle pulses; both consumers must get the same event
    always @(posedge clk) begin
        foreach (trig_cnt[i]) if (adc_trig[i] === 1'b1) trig_cnt[i]++;
        if (adc_trig !== dma_trig) pair_err++;
    end
    // slow edges, four cycles a level, so the input synchroniser cannot miss one
    task automatic send_edges(input int t, input int n);
        repeat (n) begin
            @(posedge clk);
            edge_out[t] <= 1'b1;
            repeat (4) @(posedge clk);
            edge_out[t] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule
